// file: common/adc_seq_defs.svh
// constants for the scan sequencer: widths, counts, timing
// assumes inclusion from the package and the design file by bare name
// ----------------------------------------
// Notes on behaviour
// ----------------------------------------
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define RES_W 10
`define CH_N 8
`define CH_W 4
`define CH_EXT 4'h8
`define CH_DIAG 4'h9
`define SAMP_W 8
`define CONV_TIME_NS 1000
`define CLK_PERIOD_NS 100
// conversion budget in cycles at the design clock, at least one
`define CONV_CYC (((`CONV_TIME_NS / `CLK_PERIOD_NS) > 0) ? (`CONV_TIME_NS / `CLK_PERIOD_NS) : 1)
`define SAR_BITS 10
`define MODE_SINGLE 2'h0
`define MODE_SSCAN 2'h1
`define MODE_CSCAN 2'h2
`endif

// file: common/adc_seq_pkg.sv
// types for the scan sequencer
// assumes adc_seq_defs.svh is on the include path
package adc_seq_pkg;
`include "adc_seq_defs.svh"
  typedef logic [1:0] mode_t;
  typedef struct packed {
    mode_t mode;
    logic [`CH_N-1:0] ch_sel;
    logic ext_en;
    logic diag_en;
    logic [`SAMP_W-1:0] samp_states;
    logic irq_en;
    logic dma_en;
  } cfg_s;
  typedef struct packed {
    logic [`CH_W-1:0] chan;
    logic [`RES_W-1:0] data;
  } result_s;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMP = 4'b0010,
    ST_CONV = 4'b0100,
    ST_NEXT = 4'b1000
  } state_e;
endpackage

// file: hw/adc_scan_sequencer.sv
// control and sequencing of a 10-bit successive approximation converter
// assumes analog comparator output on the same clock; external trigger is async
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module adc_scan_sequencer (
  input wire logic mclk_in, // 10 MHz clock
  input wire logic rst_b_in, // sync reset, active low
  input wire logic module_stop_in, // halt, no conversions
  input wire adc_seq_pkg::cfg_s cfg_in, // mode, channels, sampling
  input wire logic sw_start_in, // software trigger pulse
  input wire logic sw_stop_in, // ends continuous scan
  input wire logic timer_trig_in, // on-chip timer event pulse
  input wire logic timer_trig_en_in, // timer trigger enable
  input wire logic ext_trig_b_in, // external_conversion_trigger, async, active low
  input wire logic ext_trig_en_in, // external trigger enable
  input wire logic comp_in, // sar comparator: input at or above dac
  output logic [`CH_W-1:0] mux_sel_out, // analog mux select
  output logic sample_out, // sample switch closed
  output logic [`RES_W-1:0] dac_out, // sar trial code
  output logic busy_out, // conversion or pass in progress
  output adc_seq_pkg::result_s result_out, // last result
  output logic result_valid_out, // result strobe
  output logic conversion_end_irq_out, // end interrupt pulse
  output logic dma_req_out // dma/dtc activation pulse
);
  import adc_seq_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // lowest selected target at or above start; 4'hf when none
  function automatic logic [`CH_W-1:0] next_ch(input logic [`CH_N+1:0] sel,
                                               input logic [`CH_W-1:0] start);
    logic [`CH_W-1:0] r;
    r = 4'hf;
    for (int i = `CH_N + 1; i >= 0; i--) begin
      if (sel[i] && (4'(i) >= start)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // trigger capture
  // ----------------------------------------
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_s3_q <= 1'b1;
    end else begin
      ext_s1_q <= ext_trig_b_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  logic ext_fall, trig;
  assign ext_fall = ext_s3_q && !ext_s2_q;
  assign trig = sw_start_in || (timer_trig_in && timer_trig_en_in)
                || (ext_fall && ext_trig_en_in);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  state_e st_q;
  logic [`CH_W-1:0] ch_q;
  logic [`SAMP_W-1:0] samp_cnt_q;
  logic [3:0] bit_q;
  logic [`RES_W-1:0] sar_q;
  logic stop_req_q;
  logic [`CH_N+1:0] sel_all;
  logic [`CH_W-1:0] first_ch, after_ch;
  logic last_ch;

  // mode picks one target or a mask
  assign sel_all = (cfg_in.mode == `MODE_SINGLE) ? '0 :
                   {cfg_in.diag_en, cfg_in.ext_en, cfg_in.ch_sel};
  assign first_ch = (cfg_in.mode == `MODE_SINGLE) ? cfg_in.ch_sel[`CH_W-1:0] :
                    next_ch(sel_all, 4'h0);
  assign after_ch = (ch_q == 4'hf) ? 4'hf : next_ch(sel_all, ch_q + 4'h1);
  assign last_ch = (cfg_in.mode == `MODE_SINGLE) || (after_ch == 4'hf);

  logic pass_end;
  assign pass_end = (st_q == ST_NEXT) && last_ch;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      stop_req_q <= 1'b0;
    end else if (st_q == ST_IDLE) begin
      stop_req_q <= 1'b0;
    end else if (sw_stop_in) begin
      stop_req_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || module_stop_in) begin
      st_q <= ST_IDLE;
      ch_q <= 4'h0;
      samp_cnt_q <= 8'h00;
      bit_q <= 4'h0;
      sar_q <= 10'h000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (trig && first_ch != 4'hf) begin
            st_q <= ST_SAMP;
            ch_q <= first_ch;
            samp_cnt_q <= cfg_in.samp_states;
          end
        end
        ST_SAMP: begin
          if (samp_cnt_q <= 8'h01) begin
            st_q <= ST_CONV;
            bit_q <= 4'(`SAR_BITS - 1);
            sar_q <= 10'h200;
          end else begin
            samp_cnt_q <= samp_cnt_q - 8'h01;
          end
        end
        ST_CONV: begin
          // one trial per cycle, using the whole ten-cycle budget
          if (!comp_in) begin
            sar_q[bit_q] <= 1'b0;
          end
          if (bit_q == 4'h0) begin
            st_q <= ST_NEXT;
          end else begin
            sar_q[bit_q - 4'h1] <= 1'b1;
            bit_q <= bit_q - 4'h1;
          end
        end
        ST_NEXT: begin
          // one channel at a time, pass control
          if (!last_ch) begin
            st_q <= ST_SAMP;
            ch_q <= after_ch;
            samp_cnt_q <= cfg_in.samp_states;
          end else if (cfg_in.mode == `MODE_CSCAN && !stop_req_q && !sw_stop_in) begin
            st_q <= ST_SAMP;
            ch_q <= next_ch(sel_all, 4'h0);
            samp_cnt_q <= cfg_in.samp_states;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // result tagged with its target, incl. extended and diagnostic
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      result_out <= '0;
      result_valid_out <= 1'b0;
    end else begin
      // module stop discards a finished result too
      result_valid_out <= (st_q == ST_NEXT) && !module_stop_in;
      if (st_q == ST_NEXT && !module_stop_in) begin
        result_out <= '{chan: ch_q, data: sar_q};
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      conversion_end_irq_out <= 1'b0;
      dma_req_out <= 1'b0;
    end else begin
      conversion_end_irq_out <= pass_end && cfg_in.irq_en && !module_stop_in;
      dma_req_out <= pass_end && cfg_in.dma_en && !module_stop_in;
    end
  end

  assign mux_sel_out = ch_q;
  assign sample_out = (st_q == ST_SAMP);
  assign dac_out = sar_q;
  assign busy_out = (st_q != ST_IDLE);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // run lengths of sampling and conversion, for the length checks
  logic [7:0] samp_len_q;
  logic [3:0] conv_len_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      samp_len_q <= 8'h00;
      conv_len_q <= 4'h0;
    end else begin
      samp_len_q <= (st_q == ST_SAMP) ? samp_len_q + 8'h01 : 8'h00;
      conv_len_q <= (st_q == ST_CONV) ? conv_len_q + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  busy_ignore_a: assert property ((st_q == ST_CONV) && !module_stop_in |=> st_q != ST_IDLE)
    else $error("conversion abandoned without stop");
  stop_idle_a: assert property (module_stop_in |=> !busy_out)
    else $error("busy while module stopped");
  one_sample_a: assert property ((st_q == ST_CONV) |-> !sample_out && $stable(mux_sel_out))
    else $error("input changed during conversion");
  conv_len_a: assert property ((st_q == ST_NEXT) |-> conv_len_q == 4'(`SAR_BITS))
    else $error("conversion length wrong");
  irq_cause_a: assert property (conversion_end_irq_out |-> $past(pass_end) && cfg_in.irq_en)
    else $error("irq without pass end");
  result_bit_a: assert property (result_valid_out |-> result_out.chan == $past(ch_q))
    else $error("result channel mismatch");
  single_stop_a: assert property (pass_end && cfg_in.mode == `MODE_SINGLE
    && !module_stop_in |=> st_q == ST_IDLE)
    else $error("single mode did not stop");
  sscan_stop_a: assert property (pass_end && cfg_in.mode == `MODE_SSCAN
    && !module_stop_in |=> st_q == ST_IDLE)
    else $error("single scan repeated");
  ascend_a: assert property ((st_q == ST_NEXT) && !last_ch && !module_stop_in
    |=> ch_q > $past(ch_q))
    else $error("channel order not ascending");
  samp_len_a: assert property ((st_q == ST_CONV) && (samp_len_q != 8'h00)
    |-> samp_len_q == ((cfg_in.samp_states == 8'h00) ? 8'h01 : cfg_in.samp_states))
    else $error("sampling length wrong");

  single_c: cover property (pass_end && cfg_in.mode == `MODE_SINGLE);
  sscan_c: cover property (pass_end && cfg_in.mode == `MODE_SSCAN);
  cscan_c: cover property (pass_end && cfg_in.mode == `MODE_CSCAN ##1 busy_out);
  ext_c: cover property (ext_fall && ext_trig_en_in && !busy_out);
endmodule

// file: dv/analog_source_model.sv
// analog side model: one fixed level per target, comparator against trial code
// assumes the sequencer drives mux select and trial code on the same clock
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module analog_source_model (
  input wire logic [`CH_W-1:0] mux_sel_in, // selected target
  input wire logic [`RES_W-1:0] dac_in, // trial code
  output logic comp_out // level at or above trial code
);
  // level depends on the target so each result shows its source
  always_comb begin
    comp_out = (10'h05a + {6'h00, mux_sel_in} * 10'h047) >= dac_in;
  end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the scan sequencer
// assumes the analog model closes the comparator loop
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module tb_top;
  import adc_seq_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic module_stop_in = 1'b0;
  cfg_s cfg_in = '0;
  logic sw_start_in = 1'b0;
  logic sw_stop_in = 1'b0;
  logic timer_trig_in = 1'b0;
  logic timer_trig_en_in = 1'b1;
  logic ext_trig_b_in = 1'b1;
  logic ext_trig_en_in = 1'b1;
  logic comp_in;
  logic [`CH_W-1:0] mux_sel_out;
  logic [`RES_W-1:0] dac_out;
  logic sample_out, busy_out, result_valid_out, conversion_end_irq_out, dma_req_out;
  result_s result_out;
  int n_errors = 0;
  int total_checks = 0;
  int n_res, first_at, n_irq;
  logic [31:0] seq;
  always #50 mclk_in = ~mclk_in;
  adc_scan_sequencer i_dut (.mclk_in, .rst_b_in, .module_stop_in, .cfg_in, .sw_start_in,
    .sw_stop_in, .timer_trig_in, .timer_trig_en_in, .ext_trig_b_in, .ext_trig_en_in,
    .comp_in, .mux_sel_out, .sample_out, .dac_out, .busy_out, .result_out,
    .result_valid_out, .conversion_end_irq_out, .dma_req_out);
  analog_source_model i_src (.mux_sel_in(mux_sel_out), .dac_in(dac_out), .comp_out(comp_in));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic setcfg(input mode_t m, input logic [7:0] s, input logic e, input logic d,
                        input logic [7:0] n);
    @(posedge mclk_in);
    cfg_in <= '{m, s, e, d, n, 1'b1, 1'b1};
  endtask
  // kind 0 software, 1 timer, 2 external pin
  task automatic trig(input int k);
    @(posedge mclk_in);
    sw_start_in <= (k == 0);
    timer_trig_in <= (k == 1);
    ext_trig_b_in <= (k != 2);
    @(posedge mclk_in);
    sw_start_in <= 1'b0;
    timer_trig_in <= 1'b0;
    ext_trig_b_in <= 1'b1;
  endtask
  // gather results until busy falls; stop pulse while stop_at results seen
  task automatic collect(input int stop_at);
    logic seen;
    seen = 1'b0;
    n_res = 0;
    first_at = 0;
    n_irq = 0;
    seq = '0;
    for (int i = 1; i < 400; i++) begin
      @(posedge mclk_in);
      sw_stop_in <= (n_res == stop_at);
      #1;
      if (busy_out === 1'b1) seen = 1'b1;
      if (result_valid_out === 1'b1) begin
        if (n_res == 0) first_at = i;
        n_res++;
        seq = {seq[27:0], result_out.chan};
        chk("data", 10'h05a + {6'h00, result_out.chan} * 10'h047, result_out.data);
      end
      if (conversion_end_irq_out === 1'b1) n_irq++;
      chk("irq with dma", conversion_end_irq_out, dma_req_out);
      if (seen && busy_out !== 1'b1) return;
    end
    n_errors++;
    $display("CHECK FAILED busy wait expected idle seen busy");
    close_out();
  endtask
  task automatic quiet(input string what);
    logic b;
    b = 1'b0;
    repeat (20) begin
      @(posedge mclk_in);
      #1;
      b = b | busy_out | result_valid_out | conversion_end_irq_out;
    end
    chk(what, 0, b);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // latency counts from the first edge after the taking edge
  task automatic t_single(input logic [3:0] ch, input logic [7:0] n);
    logic [7:0] ns;
    ns = (n == 8'h00) ? 8'h01 : n;
    setcfg(`MODE_SINGLE, {4'h0, ch}, 1'b0, 1'b0, n);
    trig(0);
    collect(-1);
    chk("latency", {24'h0, ns} + 32'(`SAR_BITS + 1), first_at);
    chk("single count", 1, n_res);
    chk("single chan", ch, seq);
    chk("single irq", 1, n_irq);
  endtask
  task automatic t_scan();
    setcfg(`MODE_SSCAN, 8'h25, 1'b0, 1'b1, 8'h02);
    trig(1);
    collect(-1);
    chk("scan order", 32'h0259, seq);
    chk("scan irq", 1, n_irq);
  endtask
  task automatic t_cont();
    setcfg(`MODE_CSCAN, 8'h81, 1'b1, 1'b0, 8'h01);
    trig(2);
    collect(4);
    chk("cont order", 32'h078078, seq);
    chk("cont irq", 2, n_irq);
  endtask
  // collect starts eight edges after the start; a restart would delay the result
  task automatic t_busy();
    setcfg(`MODE_SINGLE, 8'h01, 1'b0, 1'b0, 8'h02);
    trig(0);
    repeat (2) @(posedge mclk_in);
    trig(2);
    trig(0);
    trig(1);
    collect(-1);
    chk("busy retrig count", 1, n_res);
    chk("busy retrig latency", 32'(`SAR_BITS + 2 + 1 - 8), first_at);
    quiet("idle after retrig");
  endtask
  task automatic t_stop();
    setcfg(`MODE_SINGLE, 8'h02, 1'b0, 1'b0, 8'h04);
    trig(0);
    repeat (5) @(posedge mclk_in);
    module_stop_in <= 1'b1;
    trig(0);
    quiet("module stop");
    @(posedge mclk_in);
    module_stop_in <= 1'b0;
  endtask
  // disabled timer and pin triggers must not start anything
  task automatic t_gate();
    setcfg(`MODE_SINGLE, 8'h04, 1'b0, 1'b0, 8'h00);
    timer_trig_en_in <= 1'b0;
    ext_trig_en_in <= 1'b0;
    trig(1);
    trig(2);
    quiet("gated triggers");
    @(posedge mclk_in);
    timer_trig_en_in <= 1'b1;
    ext_trig_en_in <= 1'b1;
  endtask
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    t_single(4'h3, 8'h02);
    t_single(4'h9, 8'h05);
    t_scan();
    t_cont();
    t_busy();
    t_stop();
    t_gate();
    t_single(4'h4, 8'h00);
    close_out();
  end
endmodule
